// file: rtl/hsc_pkg.sv
package hsc_pkg;
	// Counter data width
	localparam int HSC_W = 16;

	// Register word indices; byte address is index times four
	localparam logic [2:0] IDX_STATUS = 3'h0;
	localparam logic [2:0] IDX_PRESET = 3'h1;
	localparam logic [2:0] IDX_ACC = 3'h2;
	localparam logic [2:0] IDX_CTRL = 3'h3;
	localparam logic [2:0] IDX_LOW = 3'h4;
	localparam logic [2:0] IDX_CMD = 3'h5;
	localparam logic [2:0] IDX_HWACC = 3'h6;
	localparam logic [2:0] IDX_HIGHHW = 3'h7;

	// Status word bit positions
	localparam int B_UP = 15;
	localparam int B_DOWN = 14;
	localparam int B_HTL = 13;
	localparam int B_WH = 12;
	localparam int B_WL = 11;
	localparam int B_REF = 10;
	localparam int B_HI = 9;
	localparam int B_LO = 8;
	localparam int B_CWH = 7;
	localparam int B_CWL = 6;
	localparam int B_CHT = 5;
	localparam int B_CLT = 4;
	localparam int B_QUE = 3;
	localparam int B_DROP = 2;
	localparam int B_EN = 1;

	// Status masks
	localparam logic [15:0] CFG_CLR_MASK = 16'hC0F8;
	localparam logic [15:0] CFG_SET_MASK = 16'h0002;
	localparam logic [15:0] SW_W1C_MASK = 16'h3804;
	localparam logic [15:0] CMP_MASK = 16'h0300;
	localparam logic [15:0] CAUSE_MASK = 16'h00F0;
	localparam logic [15:0] STATUS_RST = 16'h0000;

	// Command register bits
	localparam int C_CLR = 0;
	localparam int C_WR = 1;
	localparam int C_ALLOW = 2;
	localparam int C_BLOCK = 3;
	localparam int C_REFRESH = 4;
	localparam int C_SERVICE = 5;
	localparam int C_VAL_LSB = 16;

	// Control register fields
	localparam int CTL_MODE_LSB = 0;
	localparam int CTL_SETUP = 4;

	// Counting modes
	localparam logic [3:0] MODE_UP = 4'h1;
	localparam logic [3:0] MODE_UP_RH = 4'h2;
	localparam logic [3:0] MODE_PDIR = 4'h3;
	localparam logic [3:0] MODE_PDIR_RH = 4'h4;
	localparam logic [3:0] MODE_UPDN = 4'h5;
	localparam logic [3:0] MODE_UPDN_RH = 4'h6;
	localparam logic [3:0] MODE_QUAD = 4'h7;
	localparam logic [3:0] MODE_QUAD_RH = 4'h8;

	// Accumulator limits
	localparam logic [15:0] ACC_MAX = 16'h7FFF;
	localparam logic [15:0] ACC_MIN = 16'h8000;
	localparam logic [15:0] ACC_ZERO = 16'h0000;
endpackage

// file: rtl/hsc_top.sv
// The implementer's own choice: the APB interface to the registers.

// Register map, word index times four
// Offset 0x00 counter_status_word, flags below
// Offset 0x04 counter_preset_word, high preset image
// Offset 0x08 counter_accumulator_word, image count
// Offset 0x0C control: mode and setup rung
// Offset 0x10 low preset
// Offset 0x14 command strobes, write only
// Offset 0x18 hardware count, read only
// Offset 0x1C hardware high preset, read only
// Other addresses answer with an error

// Status word layout
// Bit 15 up_count_active, follows the rung
// Bit 14 down_count_active, bidirectional only
// Bit 13 high_target_latch, up modes only
// Bit 12 wrap_high_flag
// Bit 11 wrap_low_flag, bidirectional only
// Bit 10 refresh_image_bit, reads as zero
// Bit 9 at_or_above_high_flag
// Bit 8 at_or_below_low_flag
// Bit 7 wrap_high_cause
// Bit 6 wrap_low_cause
// Bit 5 high_target_cause
// Bit 4 low_target_cause
// Bit 3 event_queued_flag
// Bit 2 event_dropped_flag
// Bit 1 event_enable_flag
// Bit 0 spare, reads as zero

// Status writes
// Ones on 13, 12, 11 and 2 clear them
// A one on 10 refreshes the image count
// Bits 9 and 8 writable before configuration only
// All other bits ignore software

// Command word
// Bit 0 acc_clear_op, wins over bit 1
// Bit 1 acc_write_op, value in upper half
// Bit 2 event_allow_op
// Bit 3 event_block_op
// Bit 4 image_refresh_op
// Bit 5 service start, drops queued flag

// Control word
// Bits 3:0 counting mode, 1 to 8
// Bit 4 counter_setup_op rung state
// First rung-true edge is the configuration
// It loads image count and high preset

// Count inputs
// Pin 0: up, count or encoder A
// Pin 1: direction, down or encoder B
// Pin 2: external reset, even modes
// Pin 3: hold level, even modes
// Edge to count change takes three clocks
// Pulses narrower than one clock may vanish

// Events
// Priority wrap high, wrap low, high, low
// Causes and queue need the enable flag or the configuration edge
// An event while queued marks one dropped
// Hardware sets win over software clears
// Up modes wrap to zero on the high preset
// Bidirectional modes never reload by themselves

// Bus timing
// One wait state on every access
// Read data sampled at the first access edge
// Writes land at the edge with ready high
// Refused accesses return zero data

// Reset
// Everything clears, mode falls back to 1
// Status is not retained across reset
module hsc_top
	import hsc_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [3:0] cnt_in,
	output logic event_pending
);
	logic [3:0] sync1_r;
	logic [3:0] sync2_r;
	logic [3:0] prev_r;
	logic [15:0] st_r;
	logic [15:0] st_nxt;
	logic [15:0] preset_r;
	logic [15:0] img_r;
	logic [15:0] img_nxt;
	logic [15:0] hw_acc_r;
	logic [15:0] hw_acc_nxt;
	logic [15:0] hw_high_r;
	logic [15:0] low_r;
	logic [3:0] mode_r;
	logic setup_r;
	logic configured_r;
	logic [31:0] prdata_r;
	logic pready_r;
	logic pslverr_r;

	// Input synchroniser and edge history per pin
	genvar g;
	generate
		for (g = 0; g < 4; g++) begin : g_sync
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					sync1_r[g] <= 1'b0;
					sync2_r[g] <= 1'b0;
					prev_r[g] <= 1'b0;
				end else begin
					sync1_r[g] <= cnt_in[g];
					sync2_r[g] <= sync1_r[g];
					prev_r[g] <= sync2_r[g];
				end
			end
		end
	endgenerate

	// Bus decode
	wire [2:0] idx = paddr[4:2];
	wire addr_ok = (paddr[11:5] == 7'h00) && (paddr[1:0] == 2'h0);
	wire answer = psel & penable & ~pready_r;
	wire wr_go = psel & penable & pready_r & pwrite & addr_ok;
	wire wr_status = wr_go && (idx == IDX_STATUS);
	wire wr_preset = wr_go && (idx == IDX_PRESET);
	wire wr_acc = wr_go && (idx == IDX_ACC);
	wire wr_ctrl = wr_go && (idx == IDX_CTRL);
	wire wr_low = wr_go && (idx == IDX_LOW);
	wire wr_cmd = wr_go && (idx == IDX_CMD);
	wire [15:0] wr_val = pwdata[C_VAL_LSB +: 16];

	// Operation strobes
	wire op_clear = wr_cmd & pwdata[C_CLR];
	wire op_write = wr_cmd & pwdata[C_WR] & ~pwdata[C_CLR];
	wire op_allow = wr_cmd & pwdata[C_ALLOW];
	wire op_block = wr_cmd & pwdata[C_BLOCK];
	wire op_service = wr_cmd & pwdata[C_SERVICE];
	wire op_refresh = (wr_cmd & pwdata[C_REFRESH]) | (wr_status & pwdata[B_REF]);
	wire first_cfg = setup_r & ~configured_r;

	// Mode classes
	wire up_mode = (mode_r == MODE_UP) || (mode_r == MODE_UP_RH);
	wire bidir = (mode_r >= MODE_PDIR) && (mode_r <= MODE_QUAD_RH);
	wire pdir = (mode_r == MODE_PDIR) || (mode_r == MODE_PDIR_RH);
	wire updn = (mode_r == MODE_UPDN) || (mode_r == MODE_UPDN_RH);
	wire quad = (mode_r == MODE_QUAD) || (mode_r == MODE_QUAD_RH);
	wire rh_mode = (up_mode | bidir) & ~mode_r[0];

	// Count steps from edges of the synchronised inputs
	wire [3:0] rise = sync2_r & ~prev_r;
	wire count_en = configured_r & setup_r & ~(rh_mode & sync2_r[3]);
	wire step_up = count_en & ((up_mode & rise[0]) | (pdir & rise[0] & ~sync2_r[1])
		| (updn & rise[0] & ~rise[1]) | (quad & rise[0] & ~sync2_r[1]));
	wire step_dn = count_en & ((pdir & rise[0] & sync2_r[1])
		| (updn & rise[1] & ~rise[0]) | (quad & rise[0] & sync2_r[1]));
	wire ext_rst = configured_r & rh_mode & rise[2];

	// Loads of the hardware accumulator
	wire load = op_clear | op_write | first_cfg | ext_rst;
	wire [15:0] load_val = op_clear ? ACC_ZERO : (op_write ? wr_val : (first_cfg ? img_r : ACC_ZERO));
	wire reload_high = op_clear | op_write | first_cfg;
	wire [15:0] high_src = reload_high ? preset_r : hw_high_r;
	wire [15:0] acc_plus = hw_acc_r + 16'h0001;
	wire [15:0] acc_minus = hw_acc_r - 16'h0001;

	// Preset reach, wrap and compare flags, signed compares
	wire step_hit = step_up & ~load & (acc_plus == hw_high_r);
	wire load_hit = load & ($signed(load_val) >= $signed(high_src));
	wire up_hit = up_mode & (step_hit | load_hit);
	wire ov_ev = bidir & ~load & step_up & (hw_acc_r == ACC_MAX);
	wire un_ev = bidir & ~load & step_dn & (hw_acc_r == ACC_MIN);
	wire bh_ev = bidir & (step_hit | load_hit);
	wire bl_ev = bidir & ((~load & step_dn & (acc_minus == low_r))
		| (load & ($signed(load_val) <= $signed(low_r))));
	wire cwh_ev = ov_ev | (up_hit & st_r[B_HTL]);
	wire cht_ev = bh_ev | (up_hit & ~st_r[B_HTL]);
	wire any_ev = cwh_ev | un_ev | cht_ev | bl_ev;
	wire irq = any_ev & (st_r[B_EN] | first_cfg);
	wire hi_cmp = $signed(hw_acc_r) >= $signed(hw_high_r);
	wire lo_cmp = $signed(hw_acc_r) <= $signed(low_r);

	// Hardware accumulator next value
	always_comb begin
		hw_acc_nxt = hw_acc_r;
		if (up_hit) begin
			hw_acc_nxt = ACC_ZERO;
		end else if (load) begin
			hw_acc_nxt = load_val;
		end else if (step_up) begin
			hw_acc_nxt = acc_plus;
		end else if (step_dn) begin
			hw_acc_nxt = acc_minus;
		end
	end

	// Image accumulator next value
	always_comb begin
		img_nxt = img_r;
		if (op_clear | op_write) begin
			img_nxt = load_val;
		end else if (up_hit) begin
			img_nxt = ACC_ZERO;
		end else if (op_refresh | (setup_r & configured_r)) begin
			img_nxt = hw_acc_r;
		end else if (wr_acc) begin
			img_nxt = pwdata[15:0];
		end
	end

	// Status word next value; hardware sets are applied last
	always_comb begin
		st_nxt = st_r;
		if (wr_status) begin
			st_nxt = st_nxt & ~(pwdata[15:0] & SW_W1C_MASK);
			if (!configured_r) begin
				st_nxt = (st_nxt & ~CMP_MASK) | (pwdata[15:0] & CMP_MASK);
			end
		end
		if (op_clear | op_write) begin
			st_nxt[B_HTL] = 1'b0;
			st_nxt[B_WH] = 1'b0;
			st_nxt[B_WL] = 1'b0;
			st_nxt[B_QUE] = 1'b0;
			st_nxt[B_DROP] = 1'b0;
		end
		if (op_service) begin
			st_nxt[B_QUE] = 1'b0;
		end
		if (op_allow) begin
			st_nxt[B_EN] = 1'b1;
		end else if (op_block) begin
			st_nxt[B_EN] = 1'b0;
		end
		if (first_cfg) begin
			st_nxt = (st_nxt & ~CFG_CLR_MASK) | CFG_SET_MASK;
		end
		if (up_hit) begin
			if (st_r[B_HTL]) begin
				st_nxt[B_WH] = 1'b1;
			end else begin
				st_nxt[B_HTL] = 1'b1;
			end
		end
		if (ov_ev) begin
			st_nxt[B_WH] = 1'b1;
		end
		if (un_ev) begin
			st_nxt[B_WL] = 1'b1;
		end
		if (irq) begin
			st_nxt = st_nxt & ~CAUSE_MASK;
			if (cwh_ev) begin
				st_nxt[B_CWH] = 1'b1;
			end else if (un_ev) begin
				st_nxt[B_CWL] = 1'b1;
			end else if (cht_ev) begin
				st_nxt[B_CHT] = 1'b1;
			end else begin
				st_nxt[B_CLT] = 1'b1;
			end
			st_nxt[B_DROP] = st_nxt[B_DROP] | st_r[B_QUE];
			st_nxt[B_QUE] = 1'b1;
		end
		st_nxt[B_UP] = setup_r & configured_r;
		st_nxt[B_DOWN] = setup_r & configured_r & bidir;
		if (configured_r) begin
			st_nxt[B_HI] = bidir & hi_cmp;
			st_nxt[B_LO] = bidir & lo_cmp;
		end
		if (bidir) begin
			st_nxt[B_HTL] = 1'b0;
		end
		if (up_mode) begin
			st_nxt[B_WL] = 1'b0;
		end
		st_nxt[B_REF] = 1'b0;
		st_nxt[0] = 1'b0;
	end

	// Counter element and hardware counter state
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_r <= STATUS_RST;
			img_r <= ACC_ZERO;
			hw_acc_r <= ACC_ZERO;
			hw_high_r <= ACC_ZERO;
			configured_r <= 1'b0;
		end else begin
			st_r <= st_nxt;
			img_r <= img_nxt;
			hw_acc_r <= hw_acc_nxt;
			hw_high_r <= (up_hit | reload_high) ? preset_r : hw_high_r;
			configured_r <= configured_r | setup_r;
		end
	end

	// Software-written configuration
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			preset_r <= ACC_ZERO;
			low_r <= ACC_ZERO;
			mode_r <= MODE_UP;
			setup_r <= 1'b0;
		end else begin
			preset_r <= wr_preset ? pwdata[15:0] : preset_r;
			low_r <= wr_low ? pwdata[15:0] : low_r;
			mode_r <= wr_ctrl ? pwdata[CTL_MODE_LSB +: 4] : mode_r;
			setup_r <= wr_ctrl ? pwdata[CTL_SETUP] : setup_r;
		end
	end

	// Read data selection
	wire [31:0] rd_val = (idx == IDX_STATUS) ? {16'h0000, st_r} :
		(idx == IDX_PRESET) ? {16'h0000, preset_r} :
		(idx == IDX_ACC) ? {16'h0000, img_r} :
		(idx == IDX_CTRL) ? {27'h0000000, setup_r, mode_r} :
		(idx == IDX_LOW) ? {16'h0000, low_r} :
		(idx == IDX_HWACC) ? {16'h0000, hw_acc_r} :
		(idx == IDX_HIGHHW) ? {16'h0000, hw_high_r} : 32'h00000000;

	// APB answer: one wait state, then ready
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_r <= 32'h00000000;
			pready_r <= 1'b0;
			pslverr_r <= 1'b0;
		end else begin
			pready_r <= answer;
			pslverr_r <= answer & ~addr_ok;
			if (answer) begin
				prdata_r <= (!pwrite && addr_ok) ? rd_val : 32'h00000000;
			end
		end
	end

	assign prdata = prdata_r;
	assign pready = pready_r;
	assign pslverr = pslverr_r;
	assign event_pending = st_r[B_QUE];
endmodule

// file: verif/high_speed_counter_status_tb.sv
module high_speed_counter_status_tb import hsc_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;
	typedef struct {logic wr; logic [11:0] a; logic [31:0] d; logic [15:0] e; logic er;} hsc_row_s;
	logic pclk = 1'h0;
	logic presetn = 1'h0;
	logic psel = 1'h0;
	logic penable = 1'h0;
	logic pwrite = 1'h0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic event_pending;
	logic [3:0] cnt_in;
	logic [31:0] q;
	logic er;
	int miscompares = 0;
	int checked = 0;
	int cyc = 0;
	// Plain register cases: write, or read with expected data and error
	hsc_row_s rows [10] = '{'{1'h0, 12'h000, 32'h0, 16'h0000, 1'h0}, '{1'h1, 12'h004, 32'h3, 16'h0000, 1'h0},
		'{1'h0, 12'h004, 32'h0, 16'h0003, 1'h0}, '{1'h1, 12'h010, 32'h8000, 16'h0000, 1'h0},
		'{1'h1, 12'h018, 32'h1234, 16'h0000, 1'h0}, '{1'h0, 12'h018, 32'h0, 16'h0000, 1'h0},
		'{1'h0, 12'h020, 32'h0, 16'h0000, 1'h1}, '{1'h1, 12'h00C, 32'h15, 16'h0000, 1'h0},
		'{1'h0, 12'h000, 32'h0, 16'hC002, 1'h0}, '{1'h0, 12'h01C, 32'h0, 16'h0003, 1'h0}};
	hsc_top DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .cnt_in,
		.event_pending);
	hsc_pulse_src src (.pclk, .cnt_in);
	initial begin
		forever #5 pclk = ~pclk;
	end
	// Masked compare, counted
	task chk(input logic [31:0] g, input logic [31:0] e, input logic [31:0] m);
		checked++;
		if ((g & m) !== (e & m)) begin
			miscompares++;
			$display("FAIL %0t got %h want %h", $time, g & m, e & m);
		end
	endtask
	// One APB transfer, request held until pready is seen at an edge
	task ap(input logic w, input logic [11:0] a, input logic [31:0] d);
		psel <= 1'h1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'h1;
		@(posedge pclk);
		while (pready !== 1'h1) begin
			@(posedge pclk);
		end
		q = prdata;
		er = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
		@(posedge pclk);
	endtask
	task rd(input logic [11:0] a, input logic [31:0] e, input logic [31:0] m);
		ap(1'h0, a, 32'h0);
		chk(q, e, m);
	endtask
	task cm(input logic [31:0] d);
		ap(1'h1, 12'h014, d);
	endtask
	task results;
		$display("checked %0d miscompares %0d", checked, miscompares);
		if (miscompares == 0 && checked > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	// Hang guard
	always @(posedge pclk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			miscompares++;
			results;
		end
	end
	initial begin
		repeat (4) @(posedge pclk);
		presetn <= 1'h1;
		@(posedge pclk);
		foreach (rows[i]) begin
			ap(rows[i].wr, rows[i].a, rows[i].d);
			if (!rows[i].wr) chk({q[15:0], 15'h0, er}, {rows[i].e, 15'h0, rows[i].er}, 32'hFFFF0001);
		end
		// Bidirectional counting, events and wraps
		repeat (2) src.pulse(2'h0, 2);
		rd(12'h018, 32'h2, 32'hFFFF);
		rd(12'h008, 32'h2, 32'hFFFF);
		src.pulse(2'h0, 3);
		rd(12'h000, 32'hC22A, 32'hFFFF);
		rd(12'h018, 32'h3, 32'hFFFF);
		chk({31'h0, event_pending}, 32'h1, 32'h1);
		cm(32'h00000020);
		rd(12'h000, 32'hC222, 32'hFFFF);
		cm(32'h7FFF0002);
		rd(12'h018, 32'h7FFF, 32'hFFFF);
		rd(12'h000, 32'hC22A, 32'hFFFF);
		src.pulse(2'h0, 2);
		rd(12'h000, 32'hD18E, 32'hFFFF);
		src.pulse(2'h1, 2);
		rd(12'h000, 32'hDA4E, 32'hFFFF);
		ap(1'h1, 12'h000, 32'h1804);
		rd(12'h000, 32'hC24A, 32'hFFFF);
		cm(32'h1);
		rd(12'h008, 32'h0, 32'hFFFF);
		rd(12'h000, 32'hC042, 32'hFFFF);
		cm(32'h8);
		rd(12'h000, 32'h0, 32'h2);
		cm(32'h4);
		rd(12'h000, 32'h2, 32'h2);
		// Rung false stops counting
		ap(1'h1, 12'h00C, 32'h05);
		src.pulse(2'h0, 2);
		rd(12'h000, 32'h0, 32'hC000);
		rd(12'h018, 32'h0, 32'hFFFF);
		ap(1'h1, 12'h008, 32'h55);
		rd(12'h008, 32'h55, 32'hFFFF);
		ap(1'h1, 12'h000, 32'h400);
		rd(12'h008, 32'h0, 32'hFFFF);
		ap(1'h1, 12'h008, 32'h66);
		cm(32'h10);
		rd(12'h008, 32'h0, 32'hFFFF);
		// Up mode: latch, reload and wrap on second hit
		ap(1'h1, 12'h00C, 32'h11);
		repeat (3) src.pulse(2'h0, 2);
		rd(12'h018, 32'h0, 32'hFFFF);
		rd(12'h000, 32'h2020, 32'h38F0);
		repeat (3) src.pulse(2'h0, 2);
		rd(12'h000, 32'h3080, 32'h38F0);
		// Pulse and direction with hold and reset, then encoder
		ap(1'h1, 12'h00C, 32'h14);
		src.pulse(2'h0, 2);
		rd(12'h018, 32'h1, 32'hFFFF);
		src.level(2'h3, 1'h1);
		src.pulse(2'h0, 2);
		rd(12'h018, 32'h1, 32'hFFFF);
		src.level(2'h3, 1'h0);
		src.level(2'h1, 1'h1);
		src.pulse(2'h0, 2);
		src.pulse(2'h0, 2);
		rd(12'h018, 32'hFFFF, 32'hFFFF);
		src.pulse(2'h2, 2);
		rd(12'h018, 32'h0, 32'hFFFF);
		ap(1'h1, 12'h00C, 32'h17);
		src.pulse(2'h0, 2);
		rd(12'h018, 32'hFFFF, 32'hFFFF);
		src.level(2'h1, 1'h0);
		// Reset in mid-run
		presetn <= 1'h0;
		repeat (2) @(posedge pclk);
		presetn <= 1'h1;
		@(posedge pclk);
		rd(12'h000, 32'h0, 32'hFFFF);
		results;
	end
endmodule

// file: verif/hsc_props.sv
module hsc_props (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic event_pending
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	// Address decode and completed transfer
	wire bad_a = (paddr[11:5] != 7'h00) || (paddr[1:0] != 2'h0);
	wire done = psel && penable && pready;
	wire st_rd = done && !pwrite && (paddr == 12'h000);
	a_one_wait: assert property (psel && penable && !$past(penable) |-> !pready ##1 pready)
		else $error("ready not in second access cycle");
	a_ready_pulse: assert property (pready |=> !pready)
		else $error("ready longer than one cycle");
	a_bad_addr: assert property (done && bad_a |-> pslverr && prdata == 32'h00000000)
		else $error("unmapped access not refused");
	a_good_addr: assert property (done && !bad_a |-> !pslverr)
		else $error("mapped access refused");
	a_write_zero: assert property (done && pwrite |-> prdata == 32'h00000000)
		else $error("write returned data");
	a_spare_bits: assert property (st_rd |-> prdata[10] == 1'b0 && prdata[0] == 1'b0)
		else $error("status spare bits not zero");
	a_pend_match: assert property (st_rd && $stable(event_pending) |-> prdata[3] == event_pending)
		else $error("pending output differs from status");
	a_pend_drop: assert property ($fell(event_pending) |-> $past(done && pwrite) || $past(done && pwrite, 2))
		else $error("pending cleared without software");
	c_err: cover property (done && pslverr);
	c_pend_up: cover property ($rose(event_pending));
	c_pend_down: cover property ($fell(event_pending));
endmodule
bind hsc_top hsc_props u_props (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .prdata, .pready, .pslverr,
	.event_pending);

// file: verif/hsc_pulse_src.sv
module hsc_pulse_src (
	input wire logic pclk,
	output logic [3:0] cnt_in
);
	timeunit 1ns;
	timeprecision 1ps;
	initial cnt_in = 4'h0;
	// One clean pulse, long enough for the two-flop synchroniser
	task pulse(input logic [1:0] line, input int width);
		@(posedge pclk);
		cnt_in[line] <= 1'h1;
		repeat (width) @(posedge pclk);
		cnt_in[line] <= 1'h0;
		repeat (width) @(posedge pclk);
	endtask
	// Steady level on one pin, settled through the synchroniser
	task level(input logic [1:0] line, input logic v);
		@(posedge pclk);
		cnt_in[line] <= v;
		repeat (3) @(posedge pclk);
	endtask
endmodule
